// ==== core/dsm_pkg.sv ====
// How it works
// - Selector N feeds monitoring word N only.
// - Status address selected: mirror drive status word.
// - Stopped drive mirrors as all zeros.
// - Forward accelerating mirrors as code 0x0021.
// - Forward constant speed mirrors as 0x0031.
// - Forward decelerating mirrors as code 0x0041.
// - Frequency address selected: mirror output frequency.
// - Frequency is unsigned, hundredths of a hertz.
// - Four trip entries; newest overwrites the oldest.
// - Reset fills every trip slot with 0x00FF.
// - Trips fill slots one to four, circularly.
// - Status word fields: direction, phase, health.
// - Mirrored words refresh about every 10 ms.
`default_nettype none

package dsm_pkg;

	// ****************************************************************
	// Sizes of the bank.
	// ****************************************************************
	localparam int NUM_MON = 8;   // Monitoring words and selectors.
	localparam int NUM_TRIP = 4;  // Trip log slots.
	localparam int MON_AW = 3;    // Index width for monitoring words.
	localparam int TRIP_AW = 2;   // Index width for trip slots.

	// ****************************************************************
	// Register word indexes; the byte address is four times these.
	// ****************************************************************
	localparam logic [5:0] IDX_MON_BASE = 6'h00;  // Words 1..8.
	localparam logic [5:0] IDX_TRIP_BASE = 6'h08; // Slots 1..4.
	localparam logic [5:0] IDX_SEL_BASE = 6'h10;  // Selectors 1..8.
	localparam logic [5:0] IDX_IRQ_STAT = 6'h18;  // Sticky events.
	localparam logic [5:0] IDX_IRQ_MASK = 6'h19;  // Event enables.
	localparam logic [5:0] IDX_LOG_INFO = 6'h1a;  // Log pointer, busy.

	// ****************************************************************
	// Reset values and drive parameter addresses.
	// ****************************************************************
	localparam logic [15:0] NO_TRIP = 16'h00ff;
	localparam logic [15:0] ADDR_OP_STATUS = 16'h0305;
	localparam logic [15:0] ADDR_OUT_FREQ = 16'h0311;
	localparam logic [15:0] SEL_DEFAULT = 16'h0000;

	// ****************************************************************
	// Interrupt status bit positions.
	// ****************************************************************
	localparam int IRQ_TRIP_BIT = 0;  // A trip was logged.
	localparam int IRQ_SCAN_BIT = 1;  // A refresh pass finished.
	localparam int IRQ_W = 2;
	localparam int INFO_BUSY_BIT = 4; // Refresh pass in progress.

	// ****************************************************************
	// Refresh timing.
	// ****************************************************************
	localparam int CLK_FREQ_HZ = 50_000_000;
	localparam int REFRESH_MS = 10;
	localparam int REFRESH_CYCLES = CLK_FREQ_HZ / 1000 * REFRESH_MS;

	// States of the refresh scanner.
	typedef enum logic {SCAN_IDLE, SCAN_FETCH} dsm_scan_e;

endpackage : dsm_pkg

`default_nettype wire

// ==== core/dsm_word_ram.sv ====
`default_nettype none

// ********************************************************************
// Small two-port word store with a registered read port.
// ********************************************************************
module dsm_word_ram
#(
	parameter int AW = 3,
	parameter int DW = 16
)
(
	// Clock and reset.
	input wire logic hclk,
	input wire logic hresetn,
	// Write port.
	input wire logic we,
	input wire logic [AW-1:0] waddr,
	input wire logic [DW-1:0] wdata,
	// Read port, data one cycle after the address.
	input wire logic [AW-1:0] raddr,
	output logic [DW-1:0] rdata
);

	// Storage array; contents are undefined until the first write.
	logic [DW-1:0] mem [0:(1<<AW)-1];
	// Next value of the read register.
	logic [DW-1:0] next_rdata;

	// The read returns the stored word, before a same-cycle write.
	always_comb
	begin
		next_rdata = mem[raddr];
	end

	// The array itself carries no reset.
	always_ff @(posedge hclk)
	begin
		if (we)
		begin
			mem[waddr] <= wdata;
		end
	end

	// Read data come out of a flip-flop.
	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
		begin
			rdata <= '0;
		end
		else
		begin
			rdata <= next_rdata;
		end
	end

endmodule : dsm_word_ram

`default_nettype wire

// ==== core/dsm_mirror_bank.sv ====
`default_nettype none

// ********************************************************************
// Drive status mirror and trip log bank, reached over AHB-Lite.
// ********************************************************************
module dsm_mirror_bank
	import dsm_pkg::*;
#(
	parameter int REFRESH_CYC = REFRESH_CYCLES
)
(
	// Clock and reset.
	input wire logic hclk,
	input wire logic hresetn,
	// AHB-Lite slave port.
	input wire logic hsel,
	input wire logic [31:0] haddr,
	input wire logic [1:0] htrans,
	input wire logic hwrite,
	input wire logic [2:0] hsize,
	input wire logic [31:0] hwdata,
	input wire logic hready,
	output logic hreadyout,
	output logic hresp,
	output logic [31:0] hrdata,
	// Fetch port towards the drive's parameter area.
	output logic par_req,
	output logic [15:0] par_addr,
	input wire logic par_ack,
	input wire logic [15:0] par_data,
	// Trip events from the drive.
	input wire logic trip_valid,
	input wire logic [7:0] trip_code,
	// Interrupt request.
	output logic irq
);

	// ****************************************************************
	// Declarations.
	// ****************************************************************

	// Bus decode state held from address phase into data phase.
	logic wr_pend, next_wr_pend;
	logic [5:0] wr_idx, next_wr_idx;
	logic rd_ram, next_rd_ram;
	logic [31:0] rd_q, next_rd_q;
	logic addr_ok;
	logic [5:0] a_idx;
	logic wr_now;

	// Software-written selectors and interrupt mask.
	logic [15:0] selector [NUM_MON];
	logic [15:0] next_selector [NUM_MON];
	logic [IRQ_W-1:0] irq_mask, next_irq_mask;
	logic [IRQ_W-1:0] irq_status, next_irq_status;

	// Trip log and its write pointer.
	logic [15:0] trip_slot [NUM_TRIP];
	logic [15:0] next_trip_slot [NUM_TRIP];
	logic [TRIP_AW-1:0] wr_ptr, next_wr_ptr;

	// Refresh scanner.
	dsm_scan_e scan_state, next_scan_state;
	logic [MON_AW-1:0] scan_idx, next_scan_idx;
	logic [31:0] tmr, next_tmr;
	logic refresh_tick;
	logic scan_done;

	// Monitoring word store interface.
	logic ram_we;
	logic [15:0] ram_q;

	// Word index of a byte address inside the bank.
	function automatic logic [5:0] word_idx(input logic [31:0] a);
		word_idx = a[7:2];
	endfunction : word_idx

	// True where a word index lies within [base, base + n).
	function automatic logic in_range(input logic [5:0] i,
		input logic [5:0] base, input int n);
		in_range = (i >= base) && ({26'h0, i} < {26'h0, base} + n);
	endfunction : in_range

	// ****************************************************************
	// AHB-Lite slave.
	// ****************************************************************

	// The slave never stalls and always answers OKAY.
	assign hreadyout = 1'b1;
	assign hresp = 1'b0;
	assign addr_ok = hsel && htrans[1] && hready;
	assign a_idx = word_idx(haddr);
	assign wr_now = wr_pend;

	// Read data: monitoring words from the store, others from rd_q.
	assign hrdata = rd_ram ? {16'h0000, ram_q} : rd_q;

	// Capture the address phase and prepare the read word.
	always_comb
	begin
		next_wr_pend = addr_ok && hwrite;
		next_wr_idx = a_idx;
		next_rd_ram = addr_ok && !hwrite && in_range(a_idx,
			IDX_MON_BASE, NUM_MON);
		next_rd_q = 32'h0000_0000;
		if (addr_ok && !hwrite)
		begin
			// Trip slots hold the code in the low byte.
			if (in_range(a_idx, IDX_TRIP_BASE, NUM_TRIP))
			begin
				next_rd_q = {16'h0000,
					trip_slot[a_idx[TRIP_AW-1:0]]};
			end
			else if (in_range(a_idx, IDX_SEL_BASE, NUM_MON))
			begin
				next_rd_q = {16'h0000, next_selector[a_idx[2:0]]};
			end
			else if (a_idx == IDX_IRQ_STAT)
			begin
				next_rd_q = {30'h0, irq_status};
			end
			else if (a_idx == IDX_IRQ_MASK)
			begin
				next_rd_q = {30'h0, next_irq_mask};
			end
			else if (a_idx == IDX_LOG_INFO)
			begin
				next_rd_q[TRIP_AW-1:0] = wr_ptr;
				next_rd_q[INFO_BUSY_BIT] = (scan_state == SCAN_FETCH);
			end
			else
			begin
				// Unmapped words read as zero.
				next_rd_q = 32'h0000_0000;
			end
		end
	end

	// Register the bus decode.
	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
		begin
			wr_pend <= 1'b0;
			wr_idx <= '0;
			rd_ram <= 1'b0;
			rd_q <= 32'h0000_0000;
		end
		else
		begin
			wr_pend <= next_wr_pend;
			wr_idx <= next_wr_idx;
			rd_ram <= next_rd_ram;
			rd_q <= next_rd_q;
		end
	end

	// ****************************************************************
	// Selectors, mask and interrupt status.
	// ****************************************************************

	// Data-phase writes; a read of the status clears it, events win.
	always_comb
	begin
		for (int i = 0; i < NUM_MON; i++)
		begin
			next_selector[i] = selector[i];
			// Selector i only ever steers word i.
			if (wr_now && wr_idx == IDX_SEL_BASE + 6'(i))
			begin
				next_selector[i] = hwdata[15:0];
			end
		end
		next_irq_mask = irq_mask;
		if (wr_now && wr_idx == IDX_IRQ_MASK)
		begin
			next_irq_mask = hwdata[IRQ_W-1:0];
		end
		next_irq_status = irq_status;
		if (addr_ok && !hwrite && a_idx == IDX_IRQ_STAT)
		begin
			next_irq_status = '0;
		end
		if (trip_valid)
		begin
			next_irq_status[IRQ_TRIP_BIT] = 1'b1;
		end
		if (scan_done)
		begin
			next_irq_status[IRQ_SCAN_BIT] = 1'b1;
		end
	end

	// Register the software state.
	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
		begin
			selector[0] <= ADDR_OP_STATUS;
			selector[1] <= ADDR_OUT_FREQ;
			for (int i = 2; i < NUM_MON; i++)
			begin
				selector[i] <= SEL_DEFAULT;
			end
			irq_mask <= '0;
			irq_status <= '0;
		end
		else
		begin
			selector <= next_selector;
			irq_mask <= next_irq_mask;
			irq_status <= next_irq_status;
		end
	end

	// Level interrupt while any unmasked event is pending.
	assign irq = |(irq_status & irq_mask);

	// ****************************************************************
	// Trip log.
	// ****************************************************************

	// Each trip goes to the slot at the pointer, which wraps.
	always_comb
	begin
		next_trip_slot = trip_slot;
		next_wr_ptr = wr_ptr;
		if (trip_valid)
		begin
			next_trip_slot[wr_ptr] = {8'h00, trip_code};
			next_wr_ptr = wr_ptr + 1'b1;
		end
	end

	// Power-on fills the log with the no-trip code.
	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
		begin
			for (int i = 0; i < NUM_TRIP; i++)
			begin
				trip_slot[i] <= NO_TRIP;
			end
			wr_ptr <= '0;
		end
		else
		begin
			trip_slot <= next_trip_slot;
			wr_ptr <= next_wr_ptr;
		end
	end

	// ****************************************************************
	// Refresh scanner.
	// ****************************************************************

	// Free-running period timer; a pass starts on each tick that comes while the scanner is idle.
	assign refresh_tick = (tmr == 32'(REFRESH_CYC - 1));
	assign scan_done = (scan_state == SCAN_FETCH) && par_ack &&
		(scan_idx == MON_AW'(NUM_MON - 1));

	// Walk the selectors, fetching one drive word per step.
	always_comb
	begin
		next_tmr = refresh_tick ? 32'h0000_0000 : tmr + 32'h0000_0001;
		next_scan_state = scan_state;
		next_scan_idx = scan_idx;
		case (scan_state)
			SCAN_IDLE:
			begin
				// A tick during a pass is skipped, not queued.
				if (refresh_tick)
				begin
					next_scan_state = SCAN_FETCH;
					next_scan_idx = '0;
				end
			end
			SCAN_FETCH:
			begin
				if (par_ack)
				begin
					next_scan_idx = scan_idx + 1'b1;
					if (scan_done)
					begin
						next_scan_state = SCAN_IDLE;
					end
				end
			end
			default:
			begin
				next_scan_state = SCAN_IDLE;
			end
		endcase
	end

	// Register the scanner.
	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
		begin
			tmr <= 32'h0000_0000;
			scan_state <= SCAN_IDLE;
			scan_idx <= '0;
		end
		else
		begin
			tmr <= next_tmr;
			scan_state <= next_scan_state;
			scan_idx <= next_scan_idx;
		end
	end

	// Address comes live from the selector, so edits apply next.
	assign par_req = (scan_state == SCAN_FETCH);
	assign par_addr = par_req ? selector[scan_idx] : 16'h0000;

	// The fetched word is stored unchanged: status words keep their
	// fields and codes, frequencies stay in hundredths of a hertz.
	assign ram_we = par_req && par_ack;

	// Stop, accelerate, cruise, decelerate codes pass through.
	// The same path carries codes of later phases too.
	dsm_word_ram #(
		.AW(MON_AW),
		.DW(16)
	) u_mon_ram (
		.hclk(hclk),
		.hresetn(hresetn),
		.we(ram_we),
		.waddr(scan_idx),
		.wdata(par_data),
		.raddr(a_idx[MON_AW-1:0]),
		.rdata(ram_q)
	);

	// ****************************************************************
	// Assertions.
	// ****************************************************************

	default clocking cb @(posedge hclk);
	endclocking
	default disable iff (!hresetn);

	// A fetch step: request and answer meet.
	sequence s_fetch;
		par_req && par_ack;
	endsequence

	// The last fetch of a pass.
	sequence s_last;
		s_fetch ##0 scan_idx == MON_AW'(NUM_MON - 1);
	endsequence

	property p_req_addr;
		par_req |-> par_addr == selector[scan_idx];
	endproperty
	a_req_addr: assert property (p_req_addr)
		else $error("Fetch address does not match its selector.");

	property p_step;
		s_fetch ##0 scan_idx != MON_AW'(NUM_MON - 1) |=> par_req &&
			scan_idx == $past(scan_idx) + 1'b1;
	endproperty
	a_step: assert property (p_step)
		else $error("Scanner did not advance after a fetch.");

	property p_pass_end;
		s_last |=> !par_req ##0 irq_status[IRQ_SCAN_BIT];
	endproperty
	a_pass_end: assert property (p_pass_end)
		else $error("Pass end did not idle and flag.");

	property p_tick_start;
		refresh_tick && !par_req |=> par_req && scan_idx == '0;
	endproperty
	a_tick_start: assert property (p_tick_start)
		else $error("Refresh tick did not start a pass.");

	property p_trip_store;
		trip_valid |=> trip_slot[$past(wr_ptr)] ==
			{8'h00, $past(trip_code)};
	endproperty
	a_trip_store: assert property (p_trip_store)
		else $error("Trip code not stored at pointer.");

	property p_trip_wrap;
		trip_valid && wr_ptr == TRIP_AW'(NUM_TRIP - 1) |=> wr_ptr == '0;
	endproperty
	a_trip_wrap: assert property (p_trip_wrap)
		else $error("Trip pointer did not wrap to slot one.");

	property p_trip_hold;
		!trip_valid |=> $stable(wr_ptr) && $stable(trip_slot[0]);
	endproperty
	a_trip_hold: assert property (p_trip_hold)
		else $error("Trip log changed without a trip.");

	property p_irq_trip;
		trip_valid && irq_mask[IRQ_TRIP_BIT] |=> irq;
	endproperty
	a_irq_trip: assert property (p_irq_trip)
		else $error("Masked-in trip did not raise the interrupt.");

	property p_sel_reset;
		$rose(hresetn) |-> selector[0] == ADDR_OP_STATUS &&
			trip_slot[0] == NO_TRIP && trip_slot[3] == NO_TRIP;
	endproperty
	a_sel_reset: assert property (p_sel_reset)
		else $error("Selector one not at status address after reset.");

endmodule : dsm_mirror_bank

`default_nettype wire

// ==== test/dsm_drive_model.sv ====
`default_nettype none

// ********************************************************************
// Behavioural drive answering fetches from its parameter area.
// ********************************************************************
module dsm_drive_model
	import dsm_pkg::*;
(
	// Clock and reset.
	input wire logic hclk,
	input wire logic hresetn,
	// Fetch port from the bank.
	input wire logic par_req,
	input wire logic [15:0] par_addr,
	output logic par_ack,
	output logic [15:0] par_data,
	// Live drive values and answer delay in cycles.
	input wire logic [15:0] status_word,
	input wire logic [15:0] freq_word,
	input wire logic [1:0] delay
);
	timeunit 1ns;
	timeprecision 1ps;

	logic [1:0] wait_cnt; // Cycles waited on the present fetch.

	// Word held at a parameter address; others get a scrambled address.
	function automatic logic [15:0] word_at(input logic [15:0] a);
		if (a == ADDR_OP_STATUS)
			return status_word;
		else if (a == ADDR_OUT_FREQ)
			return freq_word;
		return a ^ 16'ha5a5;
	endfunction : word_at

	// Answers each fetch after the delay; in between the data toggles.
	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
		begin
			par_ack <= 1'b0;
			par_data <= 16'h0000;
			wait_cnt <= 2'b00;
		end
		else if (par_ack || !par_req)
		begin
			par_ack <= 1'b0;
			par_data <= ~par_data;
			wait_cnt <= 2'b00;
		end
		else if (wait_cnt == delay)
		begin
			par_ack <= 1'b1;
			par_data <= word_at(par_addr);
		end
		else
		begin
			wait_cnt <= wait_cnt + 2'b01;
			par_data <= ~par_data;
		end
	end
endmodule : dsm_drive_model

`default_nettype wire

// ==== test/dsm_mirror_bank_tb.sv ====
`default_nettype none

// ********************************************************************
// Self-checking bench for the mirror and trip log bank.
// ********************************************************************
module dsm_mirror_bank_tb;
	import dsm_pkg::*;
	timeunit 1ns;
	timeprecision 1ps;

	localparam int REFRESH = 40; // Short refresh period for the run.
	logic hclk = 1'b0, hresetn = 1'b0, hsel = 1'b0, hwrite = 1'b0;
	logic [31:0] haddr = 32'h0000_0000, hwdata = 32'h0000_0000, hrdata;
	logic [1:0] htrans = 2'b00, delay = 2'b00;
	logic [2:0] hsize = 3'b010;
	logic hready, hreadyout, hresp, par_req, par_ack, irq;
	logic [15:0] par_addr, par_data;
	logic [15:0] status_word = 16'h0000, freq_word = 16'h0000;
	logic trip_valid = 1'b0;
	logic [7:0] trip_code = 8'h00;
	int fails = 0, tests_run = 0, cycles = 0;
	assign hready = hreadyout;

	dsm_mirror_bank #(.REFRESH_CYC(REFRESH)) dut (.hclk(hclk),
		.hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
		.hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready),
		.hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata),
		.par_req(par_req), .par_addr(par_addr), .par_ack(par_ack),
		.par_data(par_data), .trip_valid(trip_valid),
		.trip_code(trip_code), .irq(irq));
	dsm_drive_model drive (.hclk(hclk), .hresetn(hresetn),
		.par_req(par_req), .par_addr(par_addr), .par_ack(par_ack),
		.par_data(par_data), .status_word(status_word),
		.freq_word(freq_word), .delay(delay));

	// ****************************************************************
	// Clock, timeout and shared tasks.
	// ****************************************************************
	initial
	begin
		forever #10 hclk = ~hclk;
	end

	// A hang counts as a mismatch and closes the run.
	always @(posedge hclk)
	begin
		cycles <= cycles + 1;
		if (cycles == 19999)
		begin
			fails++;
			finish_test();
		end
	end

	task automatic finish_test();
		$display("checks %0d, mismatches %0d", tests_run, fails);
		if (fails == 0 && tests_run > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask : finish_test

	task automatic check_word(input logic [31:0] got, exp);
		tests_run++;
		if (got !== exp)
		begin
			fails++;
			$display("wrong value at %0t: got %h, expected %h", $time, got,
				exp);
		end
	endtask : check_word

	task automatic check_bit(input logic got, exp);
		tests_run++;
		if (got !== exp)
		begin
			fails++;
			$display("wrong value at %0t: got %b, expected %b", $time, got,
				exp);
		end
	endtask : check_bit

	// Byte address of word k of a register group.
	function automatic logic [31:0] at(input logic [5:0] base, int k);
		return {24'h00_0000, base + 6'(k), 2'b00};
	endfunction : at

	// One single AHB-Lite transfer; read data taken at the data edge.
	task automatic ahb(input logic w, input logic [31:0] a, wd,
		output logic [31:0] rd);
		@(posedge hclk);
		hsel <= 1'b1;
		htrans <= 2'b10;
		haddr <= a;
		hwrite <= w;
		do @(posedge hclk); while (hready !== 1'b1);
		htrans <= 2'b00;
		hsel <= 1'b0;
		hwdata <= wd;
		do @(posedge hclk); while (hready !== 1'b1);
		rd = hrdata;
	endtask : ahb

	// Waits through one whole refresh pass; gives the cycle it began.
	task automatic wait_pass(output int start);
		int n;
		n = 0;
		// Skip a pass already running so that a whole fresh one is seen.
		while (par_req !== 1'b0 && n < 2000)
		begin
			@(posedge hclk);
			n++;
		end
		while (par_req !== 1'b1 && n < 2000)
		begin
			@(posedge hclk);
			n++;
		end
		start = cycles;
		while (par_req !== 1'b0 && n < 2000)
		begin
			@(posedge hclk);
			n++;
		end
		@(posedge hclk);
	endtask : wait_pass

	// ****************************************************************
	// Scenarios.
	// ****************************************************************
	task automatic test_reset();
		logic [31:0] r;
		for (int k = 0; k < NUM_TRIP; k++)
		begin
			ahb(1'b0, at(IDX_TRIP_BASE, k), 32'h0000_0000, r);
			check_word(r, {16'h0000, NO_TRIP});
		end
		ahb(1'b0, at(IDX_SEL_BASE, 0), 32'h0000_0000, r);
		check_word(r, {16'h0000, ADDR_OP_STATUS});
		ahb(1'b0, 32'h0000_007c, 32'h0000_0000, r);
		check_word(r, 32'h0000_0000);
		check_bit(irq, 1'b0);
		check_bit(hresp, 1'b0);
	endtask : test_reset

	// Drive walks stop, accelerate, constant, decelerate forward.
	task automatic test_status();
		logic [31:0] r;
		logic [3:0] phase [4] = '{4'h0, 4'h2, 4'h3, 4'h4};
		int t;
		for (int i = 0; i < 4; i++)
		begin
			status_word <= {8'h00, phase[i], (i == 0) ? 4'h0 : 4'h1};
			freq_word <= 16'h0b54 + 16'(i); // 29.00 Hz and upward.
			wait_pass(t);
			ahb(1'b0, at(IDX_MON_BASE, 0), 32'h0000_0000, r);
			check_word(r, {24'h00_0000, phase[i], 4'(i != 0)});
			ahb(1'b0, at(IDX_MON_BASE, 1), 32'h0000_0000, r);
			check_word(r, 32'h0000_0b54 + i);
		end
	endtask : test_status

	// Slow drive, retargeted selectors, and the refresh period.
	task automatic test_selectors();
		logic [31:0] r;
		int t0, t1;
		delay <= 2'b10;
		for (int k = 2; k < NUM_MON; k++)
			ahb(1'b1, at(IDX_SEL_BASE, k), 32'h0000_0100 + k, r);
		wait_pass(t0);
		wait_pass(t1);
		check_word(32'(t1 - t0), REFRESH);
		for (int k = 2; k < NUM_MON; k++)
		begin
			ahb(1'b0, at(IDX_MON_BASE, k), 32'h0000_0000, r);
			check_word(r, (32'h0000_0100 + k) ^ 32'h0000_a5a5);
		end
		delay <= 2'b00;
	endtask : test_selectors

	// Five back-to-back trips, masked then unmasked interrupt.
	task automatic test_trips();
		logic [31:0] r;
		logic [7:0] code [5] = '{8'h3c, 8'h3d, 8'h04, 8'h02, 8'h09};
		logic [7:0] slot [4] = '{8'h09, 8'h3d, 8'h04, 8'h02};
		for (int i = 0; i < 5; i++)
		begin
			@(posedge hclk);
			trip_valid <= 1'b1;
			trip_code <= code[i];
		end
		@(posedge hclk);
		trip_valid <= 1'b0;
		repeat (2) @(posedge hclk);
		check_bit(irq, 1'b0);
		ahb(1'b1, at(IDX_IRQ_MASK, 0), 32'h0000_0001, r);
		repeat (2) @(posedge hclk);
		check_bit(irq, 1'b1);
		ahb(1'b0, at(IDX_IRQ_STAT, 0), 32'h0000_0000, r);
		check_word(r & 32'h0000_0001, 32'h0000_0001);
		repeat (2) @(posedge hclk);
		check_bit(irq, 1'b0);
		for (int k = 0; k < NUM_TRIP; k++)
		begin
			ahb(1'b0, at(IDX_TRIP_BASE, k), 32'h0000_0000, r);
			check_word(r, {24'h00_0000, slot[k]});
		end
		ahb(1'b0, at(IDX_LOG_INFO, 0), 32'h0000_0000, r);
		check_word(r & 32'h0000_0003, 32'h0000_0001);
		// One more trip with the mask open: irq rises, slot two is reused.
		@(posedge hclk);
		trip_valid <= 1'b1;
		trip_code <= 8'h3c;
		@(posedge hclk);
		trip_valid <= 1'b0;
		@(posedge hclk);
		check_bit(irq, 1'b1);
		ahb(1'b0, at(IDX_TRIP_BASE, 1), 32'h0000_0000, r);
		check_word(r, 32'h0000_003c);
	endtask : test_trips

	// Main sequence.
	initial
	begin
		repeat (6) @(posedge hclk);
		hresetn <= 1'b1;
		test_reset();
		test_status();
		test_selectors();
		test_trips();
		finish_test();
	end
endmodule : dsm_mirror_bank_tb

`default_nettype wire
